// ==== hdl/cpu_program_sequencer.sv ====
// instruction sequencer core with avalon register slave
//
// What this block does
// - four phases make one instruction cycle
// - phase one start advances pc, starts fetch
// - phases one to four execute previous fetch
// - fetch overlaps execute, one instruction per cycle
// - jump and call take two cycles
// - pc steps by one unless branching
// - software reaches only pc low byte
// - jump, call, interrupt, reset load pc directly
// - taken skip discards prefetch, inserts dummy cycle
// - pc is two high bits plus low byte
// - low byte write jumps within current page
// - low byte jump inserts one dummy cycle
// - four-level hidden stack holds pc only
// - call or interrupt acknowledge pushes pc
// - return instructions pop pc from stack
// - reset points stack pointer at top
// - full stack withholds interrupt acknowledge until return
// - call on full stack proceeds and overflows
// - alu writes accumulator or named register, updates status flags
// - alu supports arithmetic, logic, rotate, step ops
// - program memory is 1K by 14 bits
// - reset loads pc with vector zero
// - alu datapath is eight bits wide
// - table read takes two instruction cycles
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`include "seq_map.svh"
module cpu_program_sequencer
    import seq_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    // avalon-mm register slave
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // program memory
    output logic      [`PM_ADDR_W-1:0]   pm_addr,
    input  wire logic [`PM_DATA_W-1:0]   pm_data,
    // interrupt request logic
    input  wire logic                    irq_req,
    output logic                         irq_ack,
    // phase indication, one-hot instruction_cycle_phases
    output logic      [3:0]              instruction_cycle_phases
);
    phase_t                  phase_q;
    logic [3:0]              phase_oh_q;
    logic [1:0]              ctrl_q;
    logic [`PM_ADDR_W-1:0]   pc_q;
    logic [`PM_ADDR_W-1:0]   pc_d;
    logic [`PM_ADDR_W-1:0]   pm_addr_q;
    logic [`PM_ADDR_W-1:0]   pm_addr_d;
    logic [`PM_DATA_W-1:0]   ir_q;
    logic                    ir_valid_q;
    logic                    tbl_q;
    logic [2:0]              tbl_dst_q;
    logic [7:0]              acc_q;
    flags_t                  flags_q;
    logic [5:0]              tblh_q;
    logic [7:0]              gpr_q [7];
    logic                    irq_ack_q;
    logic                    wait_q;
    logic [31:0]             rdata_q;
    logic [31:0]             rdata_d;
    logic                    bus_pcl_pend_q;
    logic [7:0]              bus_pcl_q;

    logic                    cyc_end;
    logic                    exec;
    op_class_t               cls;
    logic [2:0]              ridx;
    logic [7:0]              reg_rd;
    alu_in_t                 alu_in;
    logic [7:0]              alu_res;
    flags_t                  alu_flags;
    logic                    pcl_wr_cpu;
    logic                    skip;
    logic                    branch;
    logic                    irq_take;
    logic                    bus_pcl_take;
    logic                    inval;
    logic                    push;
    logic                    pop;
    logic [`PM_ADDR_W-1:0]   pop_pc;
    logic [2:0]              depth;
    logic                    full;
    logic                    bus_wr;

    // phase sequencer: run bit stops the clock split, not the bus slave
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_T1;
        end else if (ctrl_q[`CTRL_RUN]) begin
            unique case (phase_q)
                PH_T1: phase_q <= PH_T2;
                PH_T2: phase_q <= PH_T3;
                PH_T3: phase_q <= PH_T4;
                PH_T4: phase_q <= PH_T1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            phase_oh_q <= 4'h1;
        else if (ctrl_q[`CTRL_RUN])
            phase_oh_q <= {phase_oh_q[2:0], phase_oh_q[3]};
    end

    // every architectural update lands on the edge closing t4
    assign cyc_end = ctrl_q[`CTRL_RUN] && (phase_q == PH_T4);

    // decode of the word fetched in the previous cycle
    assign exec = ir_valid_q && !tbl_q;
    assign cls  = op_class_t'(ir_q[`F_CLASS]);
    assign ridx = ir_q[`F_REG];

    always_comb begin
        if (ridx == `PCL_INDEX)
            reg_rd = pc_q[7:0];
        else
            reg_rd = gpr_q[ridx];
    end

    assign alu_in.op = alu_op_t'(ir_q[`F_ALUOP]);
    assign alu_in.a  = acc_q;
    assign alu_in.b  = reg_rd;
    assign alu_in.f  = flags_q;

    seq_alu u_alu (
        .in     (alu_in),
        .result (alu_res),
        .flags  (alu_flags)
    );

    assign pcl_wr_cpu = exec && (cls == CL_ALU) && ir_q[`F_TOREG] && (ridx == `PCL_INDEX);
    assign skip       = exec && (cls == CL_SKZ) && (reg_rd == 8'h00);
    assign branch     = exec && ((cls inside {CL_JMP, CL_CALL, CL_RET, CL_TBL}) || skip || pcl_wr_cpu);
    // a full stack holds the request off; the next return frees a level
    assign irq_take   = cyc_end && ctrl_q[`CTRL_IEN] && irq_req && !full && !branch && !tbl_q;
    assign bus_pcl_take = cyc_end && bus_pcl_pend_q && !branch && !tbl_q && !irq_take;
    assign bus_wr     = avs_write && !wait_q;

    // next fetch address
    always_comb begin
        pc_d  = pc_q + `PM_ADDR_W'(1);
        inval = 1'b0;
        push  = 1'b0;
        pop   = 1'b0;
        if (tbl_q) begin
            pc_d = pc_q;
        end else if (exec && (cls == CL_JMP)) begin
            pc_d  = ir_q[`F_TARGET];
            inval = 1'b1;
        end else if (exec && (cls == CL_CALL)) begin
            pc_d  = ir_q[`F_TARGET];
            inval = 1'b1;
            push  = 1'b1;
        end else if (exec && (cls == CL_RET)) begin
            pc_d  = pop_pc;
            inval = 1'b1;
            pop   = 1'b1;
        end else if (skip) begin
            inval = 1'b1;
        end else if (pcl_wr_cpu) begin
            pc_d  = {pc_q[9:8], alu_res};
            inval = 1'b1;
        end else if (irq_take) begin
            pc_d  = `INT_VECTOR;
            inval = 1'b1;
            push  = 1'b1;
        end else if (bus_pcl_take) begin
            pc_d  = {pc_q[9:8], bus_pcl_q};
            inval = 1'b1;
        end
        pm_addr_d = pc_d;
        if (exec && (cls == CL_TBL))
            pm_addr_d = {pc_q[9:8], acc_q};
        else if (tbl_q)
            pm_addr_d = pc_q;
    end

    seq_return_stack #(
        .DEPTH (`STACK_DEPTH),
        .W     (`PM_ADDR_W)
    ) u_stack (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .push      (push && cyc_end),
        .pop       (pop && cyc_end),
        .push_data (pc_q),
        .pop_data  (pop_pc),
        .depth     (depth),
        .full      (full)
    );

    // program counter and fetch address
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q      <= `RESET_VECTOR;
            pm_addr_q <= `RESET_VECTOR;
        end else if (cyc_end) begin
            pc_q      <= pc_d;
            pm_addr_q <= pm_addr_d;
        end
    end

    // instruction register: the fetch of one cycle is executed in the next
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ir_q       <= '0;
            ir_valid_q <= 1'b0;
        end else if (cyc_end && !tbl_q) begin
            ir_q       <= pm_data;
            ir_valid_q <= !inval;
        end
    end

    // table read: the second cycle reads the table word, the prefetch waits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tbl_q     <= 1'b0;
            tbl_dst_q <= 3'h0;
        end else if (cyc_end) begin
            tbl_q     <= exec && (cls == CL_TBL);
            tbl_dst_q <= ridx;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            tblh_q <= 6'h00;
        else if (cyc_end && tbl_q)
            tblh_q <= pm_data[13:8];
    end

    // accumulator and status
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q   <= 8'h00;
            flags_q <= '0;
        end else if (cyc_end && exec) begin
            if (cls == CL_ALU) begin
                flags_q <= alu_flags;
                if (!ir_q[`F_TOREG])
                    acc_q <= alu_res;
            end else if (cls == CL_LDI) begin
                acc_q <= ir_q[`F_IMM];
            end
        end
    end

    // working registers; index seven is the pc low byte and never stored here
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 7; i++)
                gpr_q[i] <= 8'h00;
        end else if (cyc_end) begin
            if (tbl_q && (tbl_dst_q != `PCL_INDEX))
                gpr_q[tbl_dst_q] <= pm_data[7:0];
            else if (exec && (cls == CL_ALU) && ir_q[`F_TOREG] && (ridx != `PCL_INDEX))
                gpr_q[ridx] <= alu_res;
        end
    end

    // control: acknowledge masks further interrupts, interrupt return re-enables
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RESET;
        end else begin
            if (bus_wr && (avs_address == `OFS_CTRL))
                ctrl_q <= avs_writedata[1:0];
            if (irq_take)
                ctrl_q[`CTRL_IEN] <= 1'b0;
            else if (cyc_end && exec && (cls == CL_RET) && ir_q[`F_INTERRUPT_RETURN])
                ctrl_q[`CTRL_IEN] <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            irq_ack_q <= 1'b0;
        else
            irq_ack_q <= irq_take;
    end

    // bus writes to the pc low byte wait for a cycle boundary with no branch, table read or interrupt
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bus_pcl_pend_q <= 1'b0;
            bus_pcl_q      <= 8'h00;
        end else if (bus_wr && (avs_address == `OFS_PCL)) begin
            bus_pcl_pend_q <= 1'b1;
            bus_pcl_q      <= avs_writedata[7:0];
        end else if (bus_pcl_take) begin
            bus_pcl_pend_q <= 1'b0;
        end
    end

    // avalon slave: one wait cycle, then the request is taken
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            wait_q <= 1'b1;
        else if (!wait_q)
            wait_q <= 1'b1;
        else if (avs_read || avs_write)
            wait_q <= 1'b0;
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            `OFS_PCL:  rdata_d[7:0] = pc_q[7:0];
            `OFS_CTRL: rdata_d[1:0] = ctrl_q;
            `OFS_STAT: begin
                rdata_d[`ST_PC]    = pc_q;
                rdata_d[`ST_DEPTH] = depth;
                rdata_d[`ST_FULL]  = full;
                rdata_d[`ST_FLAGS] = flags_q;
            end
            `OFS_DATA: begin
                rdata_d[`DT_ACC]  = acc_q;
                rdata_d[`DT_TBLH] = tblh_q;
            end
            default:   rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rdata_q <= 32'h0000_0000;
        else if (wait_q && avs_read)
            rdata_q <= rdata_d;
    end

    assign avs_readdata             = rdata_q;
    assign avs_waitrequest          = wait_q;
    assign pm_addr                  = pm_addr_q;
    assign irq_ack                  = irq_ack_q;
    assign instruction_cycle_phases = phase_oh_q;
endmodule : cpu_program_sequencer

// ==== hdl/seq_alu.sv ====
// eight-bit alu: arithmetic, logic, rotate, step and decimal adjust
module seq_alu
    import seq_pkg::*;
(
    // operands
    input  wire alu_in_t    in,
    // result
    output logic [7:0]      result,
    output flags_t          flags
);
    // returns {half carry, carry, sum}; subtract reuses it with b inverted
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {h[4], s};
    endfunction : add8

    logic [9:0] sum;
    logic       lo_adj;
    logic       hi_adj;

    always_comb begin
        sum    = 10'h000;
        lo_adj = 1'b0;
        hi_adj = 1'b0;
        result = in.a;
        flags  = in.f;
        unique case (in.op)
            AO_ADD, AO_ADC, AO_SUB, AO_SBC: begin
                if (in.op == AO_ADD)
                    sum = add8(in.a, in.b, 1'b0);
                else if (in.op == AO_ADC)
                    sum = add8(in.a, in.b, in.f.c);
                else if (in.op == AO_SUB)
                    sum = add8(in.a, ~in.b, 1'b1);
                else
                    sum = add8(in.a, ~in.b, in.f.c);
                result   = sum[7:0];
                flags.c  = sum[8]; // carry set means no borrow on subtract
                flags.ac = sum[9];
                flags.ov = (in.a[7] == sum[7]) ? 1'b0 : (in.op inside {AO_ADD, AO_ADC}) ?
                           (in.a[7] == in.b[7]) : (in.a[7] != in.b[7]);
            end
            AO_DAA: begin
                lo_adj  = in.f.ac || (in.a[3:0] > 4'h9);
                hi_adj  = in.f.c || (in.a > 8'h99);
                result  = in.a + (lo_adj ? 8'h06 : 8'h00) + (hi_adj ? 8'h60 : 8'h00);
                flags.c = in.f.c | hi_adj;
            end
            AO_AND:  result = in.a & in.b;
            AO_OR:   result = in.a | in.b;
            AO_XOR:  result = in.a ^ in.b;
            AO_CPL:  result = ~in.b;
            AO_RR:   result = {in.b[0], in.b[7:1]};
            AO_RRC: begin
                result  = {in.f.c, in.b[7:1]};
                flags.c = in.b[0];
            end
            AO_RL:   result = {in.b[6:0], in.b[7]};
            AO_RLC: begin
                result  = {in.b[6:0], in.f.c};
                flags.c = in.b[7];
            end
            AO_INC:  result = in.b + 8'h01;
            AO_DEC:  result = in.b - 8'h01;
            AO_PASS: result = in.a;
        endcase
        if (!(in.op inside {AO_RR, AO_RRC, AO_RL, AO_RLC, AO_PASS}))
            flags.z = (result == 8'h00);
    end
endmodule : seq_alu

// ==== hdl/seq_return_stack.sv ====
// hidden return stack of program counter values, no software access
`include "seq_map.svh"
module seq_return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int W     = `PM_ADDR_W
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    // push and pop
    input  wire logic                         push,
    input  wire logic                         pop,
    input  wire logic [W-1:0]                 push_data,
    output logic      [W-1:0]                 pop_data,
    // occupancy
    output logic      [$clog2(DEPTH+1)-1:0]   depth,
    output logic                              full
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] ptr_q;
    logic [CW-1:0] cnt_q;
    logic [PW-1:0] below;

    assign below    = (ptr_q == '0) ? PW'(DEPTH - 1) : ptr_q - PW'(1);
    assign pop_data = mem[below];
    assign depth    = cnt_q;
    assign full     = (cnt_q == CW'(DEPTH));

    // a push on a full stack still writes and wraps over the oldest entry
    always_ff @(posedge mclk) begin
        if (push)
            mem[ptr_q] <= push_data;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= '0;
            cnt_q <= '0;
        end else if (push) begin
            ptr_q <= (ptr_q == PW'(DEPTH - 1)) ? '0 : ptr_q + PW'(1);
            if (!full)
                cnt_q <= cnt_q + CW'(1);
        end else if (pop) begin
            ptr_q <= below;
            if (cnt_q != '0)
                cnt_q <= cnt_q - CW'(1);
        end
    end
endmodule : seq_return_stack

// ==== include/seq_map.svh ====
// offsets, field positions, reset values and counts of the program sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define OFS_PCL       4'h0
`define OFS_CTRL      4'h4
`define OFS_STAT      4'h8
`define OFS_DATA      4'hC
`define CTRL_RUN      0
`define CTRL_IEN      1
`define CTRL_RESET    2'h1
`define RESET_VECTOR  10'h000
`define INT_VECTOR    10'h004
`define PHASE_COUNT   4
`define STACK_DEPTH   4
`define PM_ADDR_W     10
`define PM_DATA_W     14
`define PCL_INDEX     3'h7
`define F_CLASS       13:11
`define F_ALUOP       10:7
`define F_TOREG       6
`define F_REG         2:0
`define F_IMM         7:0
`define F_TARGET      9:0
`define F_INTERRUPT_RETURN        0
`define ST_PC         9:0
`define ST_DEPTH      12:10
`define ST_FULL       13
`define ST_FLAGS      19:16
`define DT_ACC        7:0
`define DT_TBLH       13:8
`endif

// ==== include/seq_pkg.sv ====
// types shared by the sequencer, its alu and its testbench
package seq_pkg;
    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } phase_t;
    typedef enum logic [2:0] {
        CL_ALU  = 3'b000,
        CL_LDI  = 3'b001,
        CL_JMP  = 3'b010,
        CL_CALL = 3'b011,
        CL_RET  = 3'b100,
        CL_SKZ  = 3'b101,
        CL_TBL  = 3'b110,
        CL_NOP  = 3'b111
    } op_class_t;
    typedef enum logic [3:0] {
        AO_ADD  = 4'h0, AO_ADC  = 4'h1, AO_SUB  = 4'h2, AO_SBC  = 4'h3,
        AO_DAA  = 4'h4, AO_AND  = 4'h5, AO_OR   = 4'h6, AO_XOR  = 4'h7,
        AO_CPL  = 4'h8, AO_RR   = 4'h9, AO_RRC  = 4'hA, AO_RL   = 4'hB,
        AO_RLC  = 4'hC, AO_INC  = 4'hD, AO_DEC  = 4'hE, AO_PASS = 4'hF
    } alu_op_t;
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } flags_t;
    typedef struct packed {
        alu_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        flags_t     f;
    } alu_in_t;
endpackage : seq_pkg

// ==== verif/seq_checker.sv ====
// concurrent checks on the sequencer ports
`include "seq_map.svh"
module seq_checker
    import seq_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [9:0]  pm_addr,
    input wire logic [13:0] pm_data,
    input wire logic        irq_req,
    input wire logic        irq_ack,
    input wire logic [3:0]  instruction_cycle_phases
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_walk;
        instruction_cycle_phases[1] ##1 instruction_cycle_phases[2] ##1 instruction_cycle_phases[3]
            ##1 instruction_cycle_phases[0];
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_phase_onehot; $onehot(instruction_cycle_phases); endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
    property p_phase_walk; instruction_cycle_phases[0] |=> s_walk; endproperty
    a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");
    property p_fetch_hold; !instruction_cycle_phases[0] |-> $stable(pm_addr); endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address moved inside cycle");
    property p_reset_start;
        $rose(rst_b) |-> (pm_addr == `RESET_VECTOR) [*4] ##1 (pm_addr == 10'h001);
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("start not at reset vector");
    property p_ack_vector; $rose(irq_ack) |-> pm_addr == `INT_VECTOR && $past(irq_req); endproperty
    a_ack_vector: assert property (p_ack_vector) else $error("acknowledge without vector load");
    property p_ack_pulse; irq_ack |=> !irq_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge wider than one cycle");
    property p_ack_phase; irq_ack |-> instruction_cycle_phases[0]; endproperty
    a_ack_phase: assert property (p_ack_phase) else $error("acknowledge off cycle boundary");
    property p_bus_answer; (avs_read || avs_write) && avs_waitrequest |=> s_answer; endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("register access not answered");
endmodule : seq_checker
bind cpu_program_sequencer seq_checker chk_u (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .pm_data(pm_data), .irq_req(irq_req),
    .irq_ack(irq_ack), .instruction_cycle_phases(instruction_cycle_phases));

// ==== verif/seq_pm_model.sv ====
// program memory and interrupt request model facing the sequencer
module seq_pm_model
    import seq_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // program memory
    input  wire logic [9:0]    pm_addr,
    output logic      [13:0]   pm_data,
    // interrupt request
    input  wire logic          irq_raise,
    input  wire logic          irq_ack,
    output logic               irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] mem [0:1023];
    // combinational read, the core samples it at the end of t4
    assign pm_data = mem[pm_addr];
    // request stays up while acknowledge is withheld
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
        end else if (irq_raise) begin
            irq_req <= 1'b1;
        end else if (irq_ack) begin
            irq_req <= 1'b0;
        end
    end
endmodule : seq_pm_model

// ==== verif/testbench.sv ====
// self-checking bench: fetch trace, alu, skip, stack, interrupt, low byte jump
module testbench
    import seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, irq_raise = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        avs_waitrequest, irq_ack, irq_req;
    logic [9:0]  pm_addr;
    logic [13:0] pm_data;
    logic [3:0]  phases;
    logic [9:0]  tr [$];
    int          fail_count = 0, compares = 0, acks = 0, seed = 32'hEBF9BCD8;
    alu_op_t     op_tab [5] = '{AO_CPL, AO_INC, AO_DEC, AO_RR, AO_RL};
    logic [9:0]  tr_exp [16] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h008, 10'h009, 10'h010,
                                 10'h011, 10'h012, 10'h013, 10'h014, 10'h009, 10'h00A, 10'h009, 10'h00A};
    always #5 mclk = ~mclk;
    cpu_program_sequencer dut_u (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pm_addr(pm_addr), .pm_data(pm_data), .irq_req(irq_req),
        .irq_ack(irq_ack), .instruction_cycle_phases(phases));
    seq_pm_model pm_u (.mclk(mclk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_data(pm_data),
        .irq_raise(irq_raise), .irq_ack(irq_ack), .irq_req(irq_req));
    // fetch address of the first 16 instruction cycles after reset, and acknowledge count
    always @(posedge mclk) begin
        if (rst_b === 1'b1 && phases[0] === 1'b1 && tr.size() < 16) tr.push_back(pm_addr);
        if (irq_ack === 1'b1) acks++;
    end
    function automatic logic [7:0] exp_alu(alu_op_t o, logic [7:0] a);
        case (o)
            AO_CPL: return ~a;
            AO_INC: return a + 8'h01;
            AO_DEC: return a - 8'h01;
            AO_RR:  return {a[0], a[7:1]};
            default: return {a[6:0], a[7]};
        endcase
    endfunction : exp_alu
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask : chk
    // one register access; waits for waitrequest low, no fixed latency assumed
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) fail_count++;
    endtask : bus
    task automatic close_out();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    initial begin
        logic [7:0] r;
        alu_op_t    o;
        int         n;
        for (int it = 0; it < 4; it++) begin
            r = (it == 0) ? 8'hFF : 8'($random(seed));
            o = (it == 0) ? AO_INC : op_tab[$unsigned($random(seed)) % 5];
            @(posedge mclk);
            rst_b <= 1'b0;
            repeat (3) @(posedge mclk);
            tr.delete();
            for (int i = 0; i < 1024; i++) pm_u.mem[i] = 14'h3800;
            // acc=r, reg1=acc, acc=0, jump 8, call 0x10, loop; sub: acc=op(reg1), skip on reg2, load 77, return
            pm_u.mem[0] = 14'h0800 | 14'(r);
            pm_u.mem[1] = 14'h07C1;
            pm_u.mem[2] = 14'h0800;
            pm_u.mem[3] = 14'h1008;
            pm_u.mem[4] = 14'h2001;
            pm_u.mem[8] = 14'h1810;
            pm_u.mem[9] = 14'h1009;
            pm_u.mem[16] = {3'b000, o, 7'h01};
            pm_u.mem[17] = 14'h2802;
            pm_u.mem[18] = 14'h0877;
            pm_u.mem[19] = 14'h2000;
            pm_u.mem[64] = 14'h1040;
            rst_b <= 1'b1;
            n = 0;
            while (tr.size() < 16 && n < 400) begin
                @(posedge mclk);
                n++;
            end
            for (int i = 0; i < 16; i++) chk("fetch", 32'(tr[i]), 32'(tr_exp[i]));
            bus(1'b0, 4'hC, 32'h0, rd);
            chk("acc", 32'(rd[7:0]), 32'(exp_alu(o, r)));
            bus(1'b0, 4'h8, 32'h0, rd);
            chk("depth", 32'(rd[12:10]), 32'h0);
        end
        bus(1'b0, 4'h4, 32'h0, rd);
        chk("ctrl reset", rd, 32'h1);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        // request while disabled must wait, then be taken once enabled
        @(posedge mclk);
        irq_raise <= 1'b1;
        @(posedge mclk);
        irq_raise <= 1'b0;
        repeat (40) @(posedge mclk);
        chk("ack off", 32'(acks), 32'h0);
        bus(1'b1, 4'h4, 32'h3, rd);
        repeat (60) @(posedge mclk);
        chk("ack", 32'(acks), 32'h1);
        bus(1'b0, 4'h4, 32'h0, rd);
        chk("ctrl interrupt_return", rd, 32'h3);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk("depth interrupt_return", 32'(rd[12:10]), 32'h0);
        // low byte write jumps inside page zero to a self loop
        bus(1'b1, 4'h0, 32'h40, rd);
        repeat (40) @(posedge mclk);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk("page jump", 32'(rd[9:1]), 32'h20);
        bus(1'b0, 4'h0, 32'h0, rd);
        chk("low byte", 32'(rd[7:1]), 32'h20);
        close_out();
    end
endmodule : testbench
